// File: verilog/afrc_pkg.sv
// Package of register offsets, field positions, reset values and types for the fault report block
package afrc_pkg;

  // Register offsets on the control bus
  localparam logic [7:0] OFS_CHAN_FAULT   = 8'h70;
  localparam logic [7:0] OFS_GLOBAL_FLT1  = 8'h71;
  localparam logic [7:0] OFS_GLOBAL_FLT2  = 8'h72;
  localparam logic [7:0] OFS_WARN_STATUS  = 8'h73;
  localparam logic [7:0] OFS_REPORT_MASK  = 8'h74;
  localparam logic [7:0] OFS_LATCH_CFG    = 8'h75;
  localparam logic [7:0] OFS_MISC_CTRL    = 8'h76;
  localparam logic [7:0] OFS_CLEAR_CMD    = 8'h78;

  // Reset values
  localparam logic [7:0] RST_REPORT_MASK  = 8'h00;
  localparam logic [7:0] RST_LATCH_CFG    = 8'hf8;
  localparam logic [7:0] RST_MISC_CTRL    = 8'h00;
  localparam logic [6:0] RST_CLEAR_RSVD   = 7'h00;

  // Field positions in fault_report_mask
  localparam int BIT_OVERTEMP_SHUTDOWN_MASK     = 7;
  localparam int BIT_LOGIC_UV_MASK = 6;
  localparam int BIT_LOGIC_OV_MASK = 5;
  localparam int BIT_CLK_MASK      = 4;
  localparam int BIT_PWR_UV_MASK   = 3;
  localparam int BIT_PWR_OV_MASK   = 2;
  localparam int BIT_DC_MASK       = 1;
  localparam int BIT_OC_MASK       = 0;

  // Field positions in fault_latch_config
  localparam int BIT_CLK_HOLD_EN   = 5;
  localparam int BIT_OVERTEMP_SHUTDOWN_HOLD_EN  = 4;
  localparam int BIT_OTW_HOLD_EN   = 3;
  localparam int BIT_OTW_MASK      = 2;

  // Field positions in misc_detect_control and fault_clear_command
  localparam int BIT_CLK_DET_HOLD  = 7;
  localparam int BIT_AUTO_RECOVER  = 4;
  localparam int BIT_ANALOG_CLEAR  = 7;

  // Status field positions
  localparam int BIT_LEFT_DC       = 3;
  localparam int BIT_RIGHT_DC      = 2;
  localparam int BIT_LEFT_OC       = 1;
  localparam int BIT_RIGHT_OC      = 0;
  localparam int BIT_CLK_FAULT     = 2;
  localparam int BIT_PWR_OV        = 1;
  localparam int BIT_PWR_UV        = 0;
  localparam int BIT_OVERTEMP_SHUTDOWN          = 0;
  localparam int BIT_OTW           = 2;

  // Live fault levels from the analog detectors
  typedef struct packed {
    logic left_dc;
    logic right_dc;
    logic left_oc;
    logic right_oc;
    logic clock_fault;
    logic power_over;
    logic power_under;
    logic logic_over;
    logic logic_under;
    logic overtemp_shutdown;
    logic overtemp_warning;
    logic clock_detect;
  } afrc_fault_s;

  // Register bus request
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } afrc_bus_req_s;

endpackage : afrc_pkg

// File: verilog/afrc_top.sv
// Fault report mask, latch configuration, clear command and fault status registers
// How it works
// - Mask bit 7 hides shutdown; mask resets zero
// - Bits 6,5 hide logic supply under/over
// - Bit 4 hides clock fault report
// - Bits 3,2 hide power supply under/over
// - Bit 1 hides output DC faults
// - Bit 0 hides output over-current faults
// - Latch bit 5 holds clock fault; reset F8
// - Latch bit 4 holds over-temperature shutdown
// - Latch bit 3 holds over-temperature warning
// - Latch bit 2 hides over-temperature warning
// - Misc bit 7 holds or follows clock detect
// - Misc bit 4 allows shutdown auto recovery
// - Writing one to clear bit clears faults
// - Per-channel DC and over-current status readable
// - Warning status bit raised at threshold
`timescale 1ns/10ps
module afrc_top (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  // Register access port
  input  wire afrc_pkg::afrc_bus_req_s bus_req,
  output logic [7:0]                  rd_data,
  output logic                        rd_valid,
  // Live fault levels
  input  wire afrc_pkg::afrc_fault_s  fault_in,
  // Outward report and status
  output logic                        fault_report,
  output logic                        clock_detect_status,
  output logic                        fault_clear_pulse
);

  logic [7:0]  report_mask_ff;
  logic [7:0]  latch_cfg_ff;
  logic [7:0]  misc_ctrl_ff;
  logic [6:0]  clear_rsvd_ff;
  logic [11:0] held_ff;
  logic [11:0] state;
  logic        wr_clear;
  logic        nxt_report;
  logic [7:0]  nxt_rd_data;
  logic [8:0]  report_terms;
  logic [7:0]  chan_status;
  logic [7:0]  supply_status;
  logic [7:0]  shutdown_status;
  logic [7:0]  warning_status;

  // Write-one clear strobe
  // Decoded straight from the request so held faults drop at the write edge itself
  assign wr_clear = bus_req.wr_en && (bus_req.addr == afrc_pkg::OFS_CLEAR_CMD)
                    && bus_req.wdata[afrc_pkg::BIT_ANALOG_CLEAR];

  // Fault report mask; a set bit hides its fault from the outward report
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      report_mask_ff <= afrc_pkg::RST_REPORT_MASK;
    end else if (bus_req.wr_en && (bus_req.addr == afrc_pkg::OFS_REPORT_MASK)) begin
      report_mask_ff <= bus_req.wdata;
    end
  end

  // Latch configuration; reserved bits keep whatever software writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latch_cfg_ff <= afrc_pkg::RST_LATCH_CFG;
    end else if (bus_req.wr_en && (bus_req.addr == afrc_pkg::OFS_LATCH_CFG)) begin
      latch_cfg_ff <= bus_req.wdata;
    end
  end

  // Detect hold and shutdown auto recovery controls
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      misc_ctrl_ff <= afrc_pkg::RST_MISC_CTRL;
    end else if (bus_req.wr_en && (bus_req.addr == afrc_pkg::OFS_MISC_CTRL)) begin
      misc_ctrl_ff <= bus_req.wdata;
    end
  end

  // Reserved storage beside the clear command; the command bit is never stored
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clear_rsvd_ff <= afrc_pkg::RST_CLEAR_RSVD;
    end else if (bus_req.wr_en && (bus_req.addr == afrc_pkg::OFS_CLEAR_CMD)) begin
      clear_rsvd_ff <= bus_req.wdata[6:0];
    end
  end

  // Held copies of each fault, latched whatever the hold enables say; clear drops held state
  // A fault still live in the clear cycle wins, so a clear never hides it
  // Bit order matches afrc_fault_s: 11 left_dc down to 0 clock_detect
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      held_ff <= 12'h000;
    end else begin
      for (int i = 0; i < 12; i++) begin
        held_ff[i] <= (held_ff[i] && !wr_clear) || fault_in[i];
      end
      // Auto recovery: shutdown follows live level when enabled
      if (misc_ctrl_ff[afrc_pkg::BIT_AUTO_RECOVER]) begin
        held_ff[2] <= fault_in.overtemp_shutdown;
      end
    end
  end

  // Effective fault view: the held copy keeps a fault after its live level
  // has dropped, and the live level is ORed in so a new fault shows at once
  always_comb begin
    state     = fault_in;
    // Channel and supply faults are analog faults, held until cleared
    state[11] = held_ff[11] || fault_in.left_dc;
    state[10] = held_ff[10] || fault_in.right_dc;
    state[9]  = held_ff[9]  || fault_in.left_oc;
    state[8]  = held_ff[8]  || fault_in.right_oc;
    state[6]  = held_ff[6]  || fault_in.power_over;
    state[5]  = held_ff[5]  || fault_in.power_under;
    state[4]  = held_ff[4]  || fault_in.logic_over;
    state[3]  = held_ff[3]  || fault_in.logic_under;
    // Clock fault, shutdown and warning are held only when enabled, else live
    if (latch_cfg_ff[afrc_pkg::BIT_CLK_HOLD_EN]) begin
      state[7] = held_ff[7] || fault_in.clock_fault;
    end
    if (latch_cfg_ff[afrc_pkg::BIT_OVERTEMP_SHUTDOWN_HOLD_EN]) begin
      state[2] = held_ff[2] || fault_in.overtemp_shutdown;
    end
    if (latch_cfg_ff[afrc_pkg::BIT_OTW_HOLD_EN]) begin
      state[1] = held_ff[1] || fault_in.overtemp_warning;
    end
    // Clock detect either stays once seen or follows the detector
    if (misc_ctrl_ff[afrc_pkg::BIT_CLK_DET_HOLD]) begin
      state[0] = held_ff[0] || fault_in.clock_detect;
    end
  end

  // One term per report mask bit, left and right sharing the DC and over-current terms, plus the warning; a set mask bit blanks its term
  always_comb begin
    report_terms    = 9'h000;
    report_terms[0] = state[2] && !report_mask_ff[afrc_pkg::BIT_OVERTEMP_SHUTDOWN_MASK];
    report_terms[1] = state[3] && !report_mask_ff[afrc_pkg::BIT_LOGIC_UV_MASK];
    report_terms[2] = state[4] && !report_mask_ff[afrc_pkg::BIT_LOGIC_OV_MASK];
    report_terms[3] = state[7] && !report_mask_ff[afrc_pkg::BIT_CLK_MASK];
    report_terms[4] = state[5] && !report_mask_ff[afrc_pkg::BIT_PWR_UV_MASK];
    report_terms[5] = state[6] && !report_mask_ff[afrc_pkg::BIT_PWR_OV_MASK];
    report_terms[6] = (state[11] || state[10]) && !report_mask_ff[afrc_pkg::BIT_DC_MASK];
    report_terms[7] = (state[9] || state[8]) && !report_mask_ff[afrc_pkg::BIT_OC_MASK];
    // The warning is masked from the latch configuration, not the report mask
    report_terms[8] = state[1] && !latch_cfg_ff[afrc_pkg::BIT_OTW_MASK];
    nxt_report      = |report_terms;
  end

  // Outward report, registered so the pin never glitches
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fault_report <= 1'b0;
    end else begin
      fault_report <= nxt_report;
    end
  end

  // Clock detect status, held or live per the detect hold bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clock_detect_status <= 1'b0;
    end else begin
      clock_detect_status <= state[0];
    end
  end

  // Clear pulse, one cycle after the write that asks for it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fault_clear_pulse <= 1'b0;
    end else begin
      fault_clear_pulse <= wr_clear;
    end
  end

  // Status bytes from the effective fault view; reserved bits read zero
  assign chan_status     = {4'h0, state[11], state[10], state[9], state[8]};
  assign supply_status   = {5'h00, state[7], state[6], state[5]};
  assign shutdown_status = {7'h00, state[2]};
  assign warning_status  = {5'h00, state[1], 2'h0};

  // Read data mux; the clear bit always reads zero
  always_comb begin
    nxt_rd_data = 8'h00;
    case (bus_req.addr)
      afrc_pkg::OFS_CHAN_FAULT:  nxt_rd_data = chan_status;
      afrc_pkg::OFS_GLOBAL_FLT1: nxt_rd_data = supply_status;
      afrc_pkg::OFS_GLOBAL_FLT2: nxt_rd_data = shutdown_status;
      afrc_pkg::OFS_WARN_STATUS: nxt_rd_data = warning_status;
      afrc_pkg::OFS_REPORT_MASK: nxt_rd_data = report_mask_ff;
      afrc_pkg::OFS_LATCH_CFG:   nxt_rd_data = latch_cfg_ff;
      afrc_pkg::OFS_MISC_CTRL:   nxt_rd_data = misc_ctrl_ff;
      afrc_pkg::OFS_CLEAR_CMD:   nxt_rd_data = {1'b0, clear_rsvd_ff};
      default:                   nxt_rd_data = 8'h00;
    endcase
  end

  // Registered read answer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_data  <= bus_req.rd_en ? nxt_rd_data : 8'h00;
      rd_valid <= bus_req.rd_en;
    end
  end

endmodule : afrc_top

// File: dv/afrc_assertions.sv
// Checker of read, clear, report and clock detect timing
`timescale 1ns/10ps
module afrc_assertions (
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    reset,
  // Requests and faults
  input wire afrc_pkg::afrc_bus_req_s bus_req,
  input wire afrc_pkg::afrc_fault_s   fault_in,
  // Answers
  input wire logic [7:0]              rd_data,
  input wire logic                    rd_valid,
  input wire logic                    fault_report,
  input wire logic                    clock_detect_status,
  input wire logic                    fault_clear_pulse
);
  logic [7:0] mask_ff;
  logic       hold_ff;
  wire        clr_wr = bus_req.wr_en && bus_req.addr == 8'h78 && bus_req.wdata[7];
  // Copies of the mask and detect hold mode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask_ff <= 8'h00;
      hold_ff <= 1'b0;
    end else if (bus_req.wr_en) begin
      if (bus_req.addr == 8'h74) mask_ff <= bus_req.wdata;
      if (bus_req.addr == 8'h76) hold_ff <= bus_req.wdata[7];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  read_answer_a: assert property (rd_valid == $past(bus_req.rd_en))
    else $error("read answer late");
  read_idle_a: assert property (!rd_valid |-> rd_data == 8'h00)
    else $error("read data not idle");
  clear_pulse_a: assert property (clr_wr |=> fault_clear_pulse)
    else $error("no clear pulse");
  clear_only_a: assert property (!clr_wr |=> !fault_clear_pulse)
    else $error("stray clear pulse");
  clear_reads_a: assert property (bus_req.rd_en && bus_req.addr == 8'h78 |=> !rd_data[7])
    else $error("clear bit reads one");
  dc_report_a: assert property (fault_in.left_dc && !mask_ff[1] |-> ##[1:2] fault_report)
    else $error("fault not reported");
  det_follow_a: assert property (fault_in.clock_detect |-> ##[1:2] clock_detect_status)
    else $error("detect not shown");
  det_hold_a: assert property (hold_ff && $rose(clock_detect_status) |=> clock_detect_status[*3])
    else $error("detect not held");
  cover property (rd_valid);
  cover property (fault_clear_pulse);
  cover property (fault_report);
endmodule : afrc_assertions

bind afrc_top afrc_assertions u_chk (.ref_clk, .reset, .bus_req, .fault_in, .rd_data, .rd_valid,
  .fault_report, .clock_detect_status, .fault_clear_pulse);

// File: dv/testbench.sv
// Self-checking bench for the fault report registers
`timescale 1ns/10ps
module testbench;
  logic                    ref_clk, reset, rd_valid, fault_report;
  logic                    clock_detect_status, fault_clear_pulse;
  logic [7:0]              rd_data;
  logic [9:0]              ans;
  afrc_pkg::afrc_bus_req_s bus_req;
  afrc_pkg::afrc_fault_s   fault_in;
  int                      fail_count, checks;
  int                      fb [8] = '{8, 11, 6, 5, 7, 4, 3, 2};
  afrc_top u_dut (.ref_clk, .reset, .bus_req, .rd_data, .rd_valid, .fault_in, .fault_report,
    .clock_detect_status, .fault_clear_pulse);
  // Clock at 25 ns
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Clocks pass, inputs move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  // One bus cycle: take the answer after the sampling edge, release, let an idle edge pass
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    bus_req = '{wr_en: w, rd_en: !w, addr: a, wdata: d};
    step(1);
    ans = {fault_clear_pulse, rd_valid, rd_data};
    bus_req = '0;
    step(1);
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), ans[7:0], e);
    chk("rd_valid", {7'h0, ans[8]}, 8'h01);
  endtask : rd
  // Analog fault clear; the pulse stands in the cycle after the write
  task automatic clr();
    acc(1'b1, 8'h78, 8'h80);
    chk("fault_clear_pulse", {7'h0, ans[9]}, 8'h01);
  endtask : clr
  // Fault level for two cycles, then gone
  task automatic hit(input int b);
    fault_in = afrc_pkg::afrc_fault_s'(12'h1 << b);
    step(2);
    fault_in = '0;
  endtask : hit
  task automatic rep(input logic e);
    step(3);
    chk("fault_report", {7'h0, fault_report}, {7'h0, e});
  endtask : rep
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // Watchdog far beyond the expected run
  initial begin
    #50000;
    fail_count++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {fail_count, checks, reset} = '1;
    {fail_count, checks} = '0;
    bus_req = '0;
    fault_in = '0;
    step(16);
    reset = 1'b0;
    rd(8'h74, 8'h00);
    rd(8'h75, 8'hf8);
    rd(8'h76, 8'h00);
    rd(8'h77, 8'h00);
    acc(1'b1, 8'h78, 8'hff);
    rd(8'h78, 8'h7f);
    // Each mask bit hides its own fault, which stays held
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 8'h74, 8'h01 << i);
      hit(fb[i]);
      rep(1'b0);
      acc(1'b1, 8'h74, 8'h00);
      rep(1'b1);
      clr();
      rep(1'b0);
    end
    // Warning mask, status and hold enable
    acc(1'b1, 8'h75, 8'hfc);
    hit(1);
    rep(1'b0);
    rd(8'h73, 8'h04);
    acc(1'b1, 8'h75, 8'hf8);
    rep(1'b1);
    clr();
    acc(1'b1, 8'h75, 8'hf0);
    hit(1);
    rep(1'b0);
    // Clock fault and shutdown follow the live level when not held
    acc(1'b1, 8'h75, 8'hc0);
    hit(7);
    rep(1'b0);
    hit(2);
    rep(1'b0);
    clr();
    acc(1'b1, 8'h75, 8'hf0);
    // Shutdown recovers by itself
    acc(1'b1, 8'h76, 8'h10);
    hit(2);
    rep(1'b0);
    hit(11);
    rd(8'h70, 8'h08);
    rep(1'b1);
    clr();
    // Clock detect held, cleared, then live
    acc(1'b1, 8'h76, 8'h80);
    hit(0);
    step(3);
    chk("clock_detect_status", {7'h0, clock_detect_status}, 8'h01);
    clr();
    chk("clock_detect_status", {7'h0, clock_detect_status}, 8'h00);
    acc(1'b1, 8'h76, 8'h00);
    hit(0);
    chk("clock_detect_status", {7'h0, clock_detect_status}, 8'h01);
    step(2);
    chk("clock_detect_status", {7'h0, clock_detect_status}, 8'h00);
    give_verdict();
  end
endmodule : testbench
